// ---- hdl/nand_id_host.sv ----
// Host controller reading flash identification and parameter page
`default_nettype none
module nand_id_host
  import nand_host_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Flash pins
  input  wire logic [7:0]  dq_in,
  output logic      [7:0]  dq_out,
  output logic             dq_oe_n,
  output logic             cle,
  output logic             ale,
  output logic             ce_n,
  output logic             we_n,
  output logic             read_strobe_n,
  input  wire logic        ready_busy_n
);
  typedef struct packed {
    phase_t      ph;
    pins_t       pin;
    logic [2:0]  op;
    logic [3:0]  cnt;
    logic [3:0]  tmr;
    logic [2:0]  step;
    logic [39:0] id;
    logic [7:0]  stat;
    logic [31:0] addr;
    logic        need_dummy;
    logic        reset_done;
    logic        busy;
    logic        param_ok;
    logic        done;
    logic [31:0] rdata;
    logic        wait_n;
    logic [3:0]  buf_addr;
    logic        buf_we;
    logic [7:0]  buf_wd;
    logic [3:0]  buf_idx;
  } state_t;

  state_t r, nx;
  logic [7:0] dq_s1, dq_s2;
  logic rb_s1, rb_s2;
  logic [7:0] buf_rd;
  logic [7:0] id_b5;

  // Fifth identification byte
  assign id_b5 = r.id[39:32];

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    dq_s1 <= dq_in;
    dq_s2 <= dq_s1;
    rb_s1 <= ready_busy_n;
    rb_s2 <= rb_s1;
  end

  byte_store u_store (
    .clk   (clk),
    .we    (r.buf_we),
    .waddr (r.buf_addr),
    .wdata (r.buf_wd),
    .raddr (r.buf_idx),
    .rdata (buf_rd)
  );

  function automatic logic [7:0] step_cmd(input logic [2:0] op);
    case (op)
      OP_ID:      step_cmd = CMD_READ_ID;
      OP_PARAM:   step_cmd = CMD_PARAM_PAGE;
      OP_STAT_EN: step_cmd = CMD_STATUS_ENH;
      default:    step_cmd = CMD_STATUS;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    nx = r;
    nx.buf_we = 1'b0;
    nx.wait_n = 1'b0;
    // Register bus: one wait cycle, answer on the second
    if ((avs_read || avs_write) && !r.wait_n) begin
      nx.wait_n = 1'b1;
      case (avs_address)
        REG_STATUS: nx.rdata = {24'h0, r.stat[7:0]} | 32'h0;
        REG_ID_LO:  nx.rdata = r.id[31:0];
        REG_ID_HI:  nx.rdata = {24'h0, r.id[39:32]};
        REG_FIELDS: nx.rdata = {8'h00, 8'h01 << id_b5[B5_ECC_LSB +: 2],
                                8'h01 << id_b5[B5_PLN_LSB +: 2], 4'h0,
                                id_b5[B5_RSVD], id_b5[B5_SIZE_LSB +: 3]};
        REG_ADDR:   nx.rdata = r.addr;
        REG_BUF:    nx.rdata = {24'h0, buf_rd};
        REG_CTRL:   nx.rdata = {26'h0, r.param_ok, r.reset_done, r.need_dummy,
                                r.done, r.busy, rb_s2};
        default:    nx.rdata = 32'h0;
      endcase
      if (avs_address == REG_STATUS) begin
        nx.rdata = {24'h0, r.stat};
      end
    end
    // Writes land at the edge that sees waitrequest low
    if (avs_write && r.wait_n) begin
      if (avs_address == REG_ADDR) begin
        nx.addr = avs_writedata;
      end
      if (avs_address == REG_BUF) begin
        nx.buf_idx = avs_writedata[3:0];
      end
      if (avs_address == REG_CTRL && !r.busy) begin
        nx.op = avs_writedata[2:0];
        nx.busy = 1'b1;
        nx.done = 1'b0;
        nx.ph = ST_PRE;
        nx.step = 3'h0;
      end
    end
    if (r.tmr != 4'h0) begin
      nx.tmr = r.tmr - 4'h1;
    end else begin
      case (r.ph)
        ST_IDLE: nx.pin.ce_n = 1'b1;
        // Prefix commands: reset before the first parameter page only, dummy before status after an identification read
        ST_PRE: begin
          nx.pin.ce_n = 1'b0;
          if (r.op == OP_PARAM && !r.reset_done) begin
            nx.pin.dq_out = CMD_RESET;
            nx.reset_done = 1'b1;
            nx.ph = ST_CMD;
            nx.step = 3'h7;
          end else if ((r.op == OP_STATUS || r.op == OP_STAT_EN) && r.need_dummy) begin
            nx.pin.dq_out = CMD_DUMMY;
            nx.need_dummy = 1'b0;
            nx.ph = ST_CMD;
            nx.step = 3'h7;
          end else begin
            nx.pin.dq_out = step_cmd(r.op);
            nx.ph = ST_CMD;
            nx.step = 3'h0;
          end
          nx.pin.cle = 1'b1;
          nx.pin.we_n = 1'b0;
          nx.pin.dq_oe_n = 1'b0;
          nx.tmr = STROBE_CYC;
        end
        // Rising write strobe latches the cycle
        ST_CMD: begin
          nx.pin.we_n = 1'b1;
          nx.tmr = STROBE_CYC;
          if (r.pin.we_n) begin
            nx.pin.cle = 1'b0;
            nx.pin.ale = 1'b0;
            if (r.step == 3'h7) begin
              nx.ph = ST_WAIT;
            end else if (r.op == OP_STATUS) begin
              nx.ph = ST_READ_LO;
              nx.pin.dq_oe_n = 1'b1;
            end else begin
              nx.ph = ST_ADDR;
            end
          end
        end
        ST_ADDR: begin
          nx.pin.ale = 1'b1;
          nx.pin.we_n = 1'b0;
          nx.tmr = STROBE_CYC;
          nx.pin.dq_out = (r.op == OP_STAT_EN) ? row_byte(r.addr, int'(r.step))
                                               : ADDR_ZERO;
          if (r.op == OP_STAT_EN && r.step != 3'(ROW_CYCLES - 1)) begin
            nx.step = r.step + 3'h1;
            nx.ph = ST_CMD;
          end else begin
            nx.step = 3'h6;
            nx.ph = ST_CMD;
          end
          nx.cnt = 4'h0;
          if (r.op == OP_ID) begin
            nx.need_dummy = 1'b1;
          end
        end
        ST_WAIT: begin
          nx.pin.dq_oe_n = 1'b1;
          if (rb_s2) begin
            nx.ph = ST_PRE;
          end
        end
        // Falling read strobe steps the device to its next byte
        ST_READ_LO: begin
          nx.pin.dq_oe_n = 1'b1;
          nx.pin.read_strobe_n = 1'b0;
          nx.tmr = STROBE_CYC + 4'h2;
          nx.ph = ST_READ_HI;
        end
        ST_READ_HI: begin
          nx.pin.read_strobe_n = 1'b1;
          nx.tmr = STROBE_CYC;
          nx.buf_we = 1'b1;
          nx.buf_addr = r.cnt;
          nx.buf_wd = dq_s2;
          nx.cnt = r.cnt + 4'h1;
          if (r.op == OP_ID) begin
            nx.id = {dq_s2, r.id[39:8]};
          end
          if (r.op == OP_PARAM && dq_s2 != PARAM_EXP[r.cnt]) begin
            nx.param_ok = 1'b0;
          end
          if (r.op == OP_STATUS || r.op == OP_STAT_EN) begin
            nx.stat = dq_s2;
          end
          if (r.op == OP_STATUS || r.op == OP_STAT_EN ||
              (r.op == OP_ID && r.cnt == ID_LEN - 4'h1) ||
              (r.op == OP_PARAM && r.cnt == PARAM_LEN - 4'h1)) begin
            nx.ph = ST_DONE;
          end else begin
            nx.ph = ST_READ_LO;
          end
        end
        ST_DONE: begin
          nx.busy = 1'b0;
          nx.done = 1'b1;
          nx.ph = ST_IDLE;
          if (r.op == OP_ID && r.id[39 - (7 - B5_RSVD)] != 1'b0) begin
            nx.param_ok = 1'b0;
          end
        end
        default: nx.ph = ST_IDLE;
      endcase
    end
    if (r.ph == ST_PRE && r.tmr == 4'h0 && r.op == OP_PARAM) begin
      nx.param_ok = 1'b1;
    end
    if (r.ph == ST_ADDR && r.op != OP_STAT_EN) begin
      nx.step = 3'h6;
    end
    if (r.ph == ST_CMD && r.pin.we_n && r.step == 3'h6 && r.tmr == 4'h0) begin
      nx.ph = ST_WAIT;
    end
    if (r.ph == ST_WAIT && rb_s2 && r.tmr == 4'h0 && r.step == 3'h6) begin
      nx.ph = ST_READ_LO;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
      r.ph <= ST_IDLE;
      r.pin <= '{dq_out: 8'h00, dq_oe_n: 1'b1, cle: 1'b0, ale: 1'b0,
                 ce_n: 1'b1, we_n: 1'b1, read_strobe_n: 1'b1};
    end else begin
      r <= nx;
    end
  end

  assign avs_readdata = r.rdata;
  assign avs_waitrequest = !r.wait_n;
  assign dq_out = r.pin.dq_out;
  assign dq_oe_n = r.pin.dq_oe_n;
  assign cle = r.pin.cle;
  assign ale = r.pin.ale;
  assign ce_n = r.pin.ce_n;
  assign we_n = r.pin.we_n;
  assign read_strobe_n = r.pin.read_strobe_n;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_strobes_apart: assert property (@(posedge clk) disable iff (rst)
    !(!we_n && !read_strobe_n)) else $error("Write and read strobes low together");
  chk_id_cmd_code: assert property (@(posedge clk) disable iff (rst)
    (cle && !we_n && r.op == OP_ID && r.step == 3'h0) |-> dq_out == CMD_READ_ID)
    else $error("Wrong identification command");
  chk_param_cmd: assert property (@(posedge clk) disable iff (rst)
    (cle && !we_n && r.op == OP_PARAM && r.step == 3'h0) |-> dq_out == CMD_PARAM_PAGE)
    else $error("Wrong parameter command");
  chk_reset_first: assert property (@(posedge clk) disable iff (rst)
    (cle && !we_n && dq_out == CMD_PARAM_PAGE) |-> r.reset_done)
    else $error("Parameter page without reset");
  chk_dummy_first: assert property (@(posedge clk) disable iff (rst)
    (cle && !we_n && dq_out == CMD_STATUS) |-> !r.need_dummy)
    else $error("Status read without dummy");
  chk_read_pulse: assert property (@(posedge clk) disable iff (rst)
    $fell(read_strobe_n) |=> !read_strobe_n [*3] ##1 read_strobe_n)
    else $error("Read strobe width wrong");
  chk_addr_zero: assert property (@(posedge clk) disable iff (rst)
    (ale && !we_n && r.op != OP_STAT_EN) |-> dq_out == ADDR_ZERO && r.cnt == 4'h0)
    else $error("Address cycle not zero");
  chk_bus_answer: assert property (@(posedge clk) disable iff (rst)
    (avs_read && avs_waitrequest) |=> !avs_waitrequest)
    else $error("Bus answer late");
endmodule
`default_nettype wire

// ---- include/nand_host_pkg.sv ----
// Constants and types for the flash identification / parameter page host
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`default_nettype none
package nand_host_pkg;
  // Flash commands
  localparam logic [7:0] CMD_READ_ID    = 8'h90;
  localparam logic [7:0] CMD_PARAM_PAGE = 8'hec;
  localparam logic [7:0] CMD_RESET      = 8'hff;
  localparam logic [7:0] CMD_DUMMY      = 8'h00;
  localparam logic [7:0] CMD_STATUS     = 8'h70;
  localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
  localparam logic [7:0] ADDR_ZERO      = 8'h00;
  // Address field positions
  localparam int COL_LSB = 0;
  localparam int COL_MSB = 11;
  localparam int PAGE_LSB = 12;
  localparam int PAGE_MSB = 17;
  localparam int PLANE_BIT = 18;
  localparam int BLK_LSB = 19;
  localparam int BLK_MSB = 31;
  localparam int ROW_CYCLES = 3;
  // Readout lengths
  localparam logic [3:0] ID_LEN    = 4'h5;
  localparam logic [3:0] PARAM_LEN = 4'ha;
  localparam logic [3:0] BUF_DEPTH = 4'ha;
  // Expected parameter page prefix
  localparam logic [7:0] PARAM_EXP [10] = '{8'h4f, 8'h4e, 8'h46, 8'h49,
    8'h02, 8'h00, 8'h1e, 8'h00, 8'h3b, 8'h00};
  // Byte-5 field positions
  localparam int B5_ECC_LSB = 0;
  localparam int B5_PLN_LSB = 2;
  localparam int B5_SIZE_LSB = 4;
  localparam int B5_RSVD = 7;
  // Timing at 10 MHz: STROBE_CYC of one cycle (100 ns); write strobe low two cycles and high four between cycles, read strobe low four
  localparam int CLK_NS = 100;
  localparam int STROBE_NS = 100;
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  // Avalon register offsets (word addresses)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_ID_LO  = 4'h2;
  localparam logic [3:0] REG_ID_HI  = 4'h3;
  localparam logic [3:0] REG_FIELDS = 4'h4;
  localparam logic [3:0] REG_ADDR   = 4'h5;
  localparam logic [3:0] REG_BUF    = 4'h6;
  localparam logic [2:0] OP_ID      = 3'h1;
  localparam logic [2:0] OP_PARAM   = 3'h2;
  localparam logic [2:0] OP_STATUS  = 3'h3;
  localparam logic [2:0] OP_STAT_EN = 3'h4;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000, ST_CMD = 4'b0001, ST_ADDR = 4'b0011, ST_WAIT = 4'b0010,
    ST_READ_LO = 4'b0110, ST_READ_HI = 4'b0111, ST_DONE = 4'b0101,
    ST_PRE = 4'b0100
  } phase_t;

  typedef struct packed {
    logic [7:0] dq_out;
    logic       dq_oe_n;
    logic       cle;
    logic       ale;
    logic       ce_n;
    logic       we_n;
    logic       read_strobe_n;
  } pins_t;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } avs_req_t;

  function automatic logic [7:0] row_byte(input logic [31:0] a, input int k);
    logic [31:0] s;
    s = a >> (PAGE_LSB + 8 * k);
    return s[7:0];
  endfunction
endpackage
`default_nettype wire

// ---- hdl/byte_store.sv ----
// Small byte memory with registered read data
`default_nettype none
module byte_store
  import nand_host_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Write port
  input  wire logic       we,
  input  wire logic [3:0] waddr,
  input  wire logic [7:0] wdata,
  // Read port
  input  wire logic [3:0] raddr,
  output logic      [7:0] rdata
);
  logic [7:0] mem [BUF_DEPTH];
  always_ff @(posedge clk) begin
    if (we && waddr < BUF_DEPTH) begin
      mem[waddr] <= wdata;
    end
    rdata <= (raddr < BUF_DEPTH) ? mem[raddr] : 8'h00;
  end
endmodule
`default_nettype wire

// ---- tb/nand_flash_model.sv ----
// Behavioural flash device answering identification, parameter page and status
`default_nettype none
module nand_flash_model
  import nand_host_pkg::*;
#(
  parameter logic [39:0] ID_CODE = 40'h26_88_71_3c_a7
)(
  // Host-driven pins
  input  wire logic [7:0] dq_out,
  input  wire logic       dq_oe_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       ce_n,
  input  wire logic       we_n,
  input  wire logic       read_strobe_n,
  // Device-driven pins
  output logic      [7:0] dq_in,
  output logic            ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Parameter page bytes 0..9, byte 0 lowest
  localparam logic [79:0] PAGE = 80'h00_3b_00_1e_00_02_49_46_4e_4f;
  int          busy_ns = 300;
  int          mode = 0;
  int          idx = 0;
  int          nadr = 0;
  int          reset_cnt = 0;
  logic        dummy_err = 1'b0;
  logic [7:0]  last_cmd = 8'h00;
  logic [23:0] row_r = 24'h0;
  logic [7:0]  dq_r = 8'hc3;
  logic [7:0]  bus_v;
  initial ready_busy_n = 1'b1;
  // Undriven bus latches as garbage
  assign bus_v = dq_oe_n ? ~dq_out : dq_out;
  assign dq_in = dq_r;

  function automatic logic [7:0] out_byte();
    case (mode)
      1: return (idx < 5) ? ID_CODE[8*idx +: 8] : 8'h00;
      2: return (idx < 10) ? PAGE[8*idx +: 8] : 8'h00;
      3: return 8'he0;
      4: return 8'hc0 | {6'h0, row_r[19:18]};
      default: return ~dq_r;
    endcase
  endfunction

  // ----------------------------------------
  // Command and address capture
  // ----------------------------------------
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      dummy_err = dummy_err | (bus_v == CMD_STATUS && last_cmd == CMD_READ_ID);
      last_cmd = bus_v;
      nadr = 0;
      idx = 0;
      mode = (bus_v == CMD_STATUS) ? 3 : 0;
      if (bus_v == CMD_RESET) begin
        reset_cnt++;
        ready_busy_n <= 1'b0;
        ready_busy_n <= #(busy_ns) 1'b1;
      end
    end else if (!ce_n && ale) begin
      if (last_cmd == CMD_READ_ID) mode = (nadr == 0 && bus_v == ADDR_ZERO) ? 1 : 0;
      if (last_cmd == CMD_PARAM_PAGE) begin
        mode = (nadr == 0 && bus_v == ADDR_ZERO && reset_cnt > 0) ? 2 : 0;
        ready_busy_n <= 1'b0;
        ready_busy_n <= #(busy_ns) 1'b1;
      end
      if (last_cmd == CMD_STATUS_ENH && nadr < 3) begin
        row_r[8*nadr +: 8] = bus_v;
        mode = (nadr == 2) ? 4 : 0;
      end
      nadr++;
    end
  end

  // ----------------------------------------
  // Data out on read strobe
  // ----------------------------------------
  always @(negedge read_strobe_n) begin
    if (!ce_n) begin
      dq_r <= #20 out_byte();
      idx++;
    end
  end
  // Hold time over: the byte is gone
  always @(posedge read_strobe_n) dq_r <= #15 ~dq_r;
endmodule
`default_nettype wire

// ---- tb/test_nand_id_host.sv ----
// Self-checking bench for the flash identification host
`default_nettype none
module test_nand_id_host
  import nand_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Identification bytes: arbitrary values, byte 1 lowest
  localparam logic [39:0] ID_CODE = 40'h26_88_71_3c_a7;
  localparam logic [79:0] PAGE = 80'h00_3b_00_1e_00_02_49_46_4e_4f;
  localparam logic [31:0] ADDRS [2] = '{32'h8004_0fff, 32'h7ffb_f000};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  dq_in;
  logic [7:0]  dq_out;
  logic        dq_oe_n, cle, ale, ce_n, we_n, read_strobe_n, ready_busy_n;
  int          failures = 0;
  int          samples_checked = 0;
  logic [31:0] q;

  nand_id_host dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .cle(cle), .ale(ale), .ce_n(ce_n), .we_n(we_n), .read_strobe_n(read_strobe_n),
    .ready_busy_n(ready_busy_n));
  nand_flash_model #(.ID_CODE(ID_CODE)) flash (.dq_out(dq_out), .dq_oe_n(dq_oe_n), .cle(cle),
    .ale(ale), .ce_n(ce_n), .we_n(we_n), .read_strobe_n(read_strobe_n), .dq_in(dq_in),
    .ready_busy_n(ready_busy_n));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ----------------------------------------
  // Avalon-MM master
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] rdata);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      tally_and_finish();
    end
    @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [3:0] a);
    xfer(1'b0, a, 32'h0, q);
  endtask

  // Start an operation, see it go busy, then wait for it to finish
  task automatic run_op(input logic [2:0] op);
    int n;
    n = 0;
    wr(REG_CTRL, {29'h0, op});
    do begin
      rd(REG_CTRL);
      n++;
    end while (q[1] !== 1'b1 && n < 40);
    if (q[1] !== 1'b1) begin
      failures++;
      tally_and_finish();
    end
    do begin
      rd(REG_CTRL);
      n++;
    end while (q[1] !== 1'b0 && n < 2000);
    if (n >= 2000) begin
      failures++;
      tally_and_finish();
    end
    chk("done", 32'(q[2]), 32'h1);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("idle pins", 32'({ce_n, we_n, read_strobe_n, dq_oe_n, cle, ale}), 32'h3c);
    rd(4'hf);
    chk("unmapped", q, 32'h0);
    repeat (2) begin
      run_op(OP_ID);
      chk("need_dummy", 32'(q[3]), 32'h1);
      rd(REG_ID_LO);
      chk("id_lo", q, ID_CODE[31:0]);
      rd(REG_ID_HI);
      chk("id_hi", 32'(q[7:0]), 32'(ID_CODE[39:32]));
      rd(REG_FIELDS);
      // Byte 5 = 26h: 4 ECC bits, 2 planes, size code 2, reserved bit clear
      chk("fields", q, 32'h0004_0202);
    end
    run_op(OP_STATUS);
    chk("dummy", 32'(flash.dummy_err), 32'h0);
    rd(REG_STATUS);
    chk("status", 32'(q[7:0]), 32'he0);
    for (int p = 0; p < 2; p++) begin
      flash.busy_ns = p ? 3000 : 300;
      run_op(OP_PARAM);
      chk("param_ok", 32'(q[5]), 32'h1);
      chk("resets", 32'(flash.reset_cnt), 32'h1);
      for (int i = 0; i < 10; i++) begin
        wr(REG_BUF, 32'(i));
        rd(REG_BUF);
        chk("param", 32'(q[7:0]), 32'(PAGE[8*i +: 8]));
      end
    end
    foreach (ADDRS[k]) begin
      wr(REG_ADDR, ADDRS[k]);
      run_op(OP_STAT_EN);
      chk("row", 32'(flash.row_r), {12'h0, ADDRS[k][31:12]});
      rd(REG_STATUS);
      chk("enh", 32'(q[7:0]), 32'(8'hc0 | {6'h0, ADDRS[k][31:30]}));
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
